/* ttcc_top.sv */
/*
  Three timer/counters with a four-channel capture/compare unit on timer
  two, registers on an Avalon-MM slave with waitrequest.
  Assumes pins are synchronous to clk_i and external count edges arrive
  no faster than one per 24 clocks.
*/
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ttcc_regs.svh"
module ttcc_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // timers zero and one pins
  input wire logic timer_zero_count_input_i,
  input wire logic timer_one_count_input_i,
  input wire logic ext_irq_zero_gate_i,
  input wire logic ext_irq_one_gate_i,
  // timer two pins
  input wire logic timer_two_count_gate_input_i,
  input wire logic timer_two_reload_trigger_i,
  // capture/compare pins, bit n is channel n
  input wire logic [3:0] capcmp_pin_i,
  output logic [3:0] capcmp_pin_o,
  output logic [3:0] capcmp_pin_oe_o
);

  // ************************************
  // helpers
  // ************************************
  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] be_merge(input logic [15:0] o, input logic [15:0] n,
                                           input logic [1:0] be);
    be_merge = {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction

  // one count step of timer zero/one: {overflow, next value}
  function automatic logic [16:0] t01_step(input logic [15:0] c, input logic [1:0] m);
    case (m)
      2'h0: begin
        if (c[4:0] == 5'h1F) begin // R03
          t01_step = {c[15:8] == 8'hFF, c[15:8] + 8'h01, c[7:5], 5'h00};
        end else begin
          t01_step = {1'b0, c[15:5], c[4:0] + 5'h01};
        end
      end
      2'h1: t01_step = {1'b0, c} + 17'h00001; // R04
      2'h2: begin
        if (c[7:0] == 8'hFF) begin // R05
          t01_step = {1'b1, c[15:8], c[15:8]};
        end else begin
          t01_step = {1'b0, c[15:8], c[7:0] + 8'h01};
        end
      end
      default: t01_step = {c[7:0] == 8'hFF, c[15:8], c[7:0] + 8'h01}; // R06
    endcase
  endfunction

  // ************************************
  // bus decode
  // ************************************
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [10:0] ctrl_reg;
  logic [5:0] t2c_reg;
  logic [11:0] chc_reg;
  logic [8:0] flag_reg;
  logic [15:0] tmr2_reg;
  logic [3:0] div_reg;
  logic [1:0][15:0] tmr_q;
  logic [3:0][15:0] ccv_q;
  logic [1:0] ovf01;
  logic [1:0] ovfhi;
  logic [3:0] ch_ev;
  logic [31:0] rd_mux;

  // a request is taken on the edge where waitrequest is seen low
  wire wr = avs_write_i & ~wait_reg;
  wire [15:0] wd = avs_writedata_i[15:0];
  wire [1:0] be = avs_byteenable_i[1:0];
  wire wr_ctrl = wr && avs_address_i == `TTCC_OFF_CTRL;
  wire wr_t2c = wr && avs_address_i == `TTCC_OFF_TMR2CTL;
  wire wr_chc = wr && avs_address_i == `TTCC_OFF_CHCFG;
  wire wr_flg = wr && avs_address_i == `TTCC_OFF_FLAGS;
  wire wr_tmr2 = wr && avs_address_i == `TTCC_OFF_TMR2;
  wire [1:0] wr_tmr = {wr && avs_address_i == `TTCC_OFF_TMR1,
                       wr && avs_address_i == `TTCC_OFF_TMR0};
  // offset from the first channel word; lower addresses wrap far out of range
  wire [5:0] ccv_off = avs_address_i - `TTCC_OFF_CCV0;
  wire [3:0] ccv_hit = (ccv_off[5:4] == 2'h0 && ccv_off[1:0] == 2'h0)
                       ? 4'h1 << ccv_off[3:2] : 4'h0;
  wire [3:0] wr_ccv = (wr && avs_address_i[1:0] == 2'h0) ? ccv_hit : 4'h0;

  // readback selection, unmapped words read as zero
  assign rd_mux =
    (avs_address_i == `TTCC_OFF_CTRL) ? {21'h0, ctrl_reg} :
    (avs_address_i == `TTCC_OFF_TMR2CTL) ? {26'h0, t2c_reg} :
    (avs_address_i == `TTCC_OFF_CHCFG) ? {20'h0, chc_reg} :
    (avs_address_i == `TTCC_OFF_FLAGS) ? {23'h0, flag_reg} :
    (avs_address_i == `TTCC_OFF_TMR0) ? {16'h0, tmr_q[0]} :
    (avs_address_i == `TTCC_OFF_TMR1) ? {16'h0, tmr_q[1]} :
    (avs_address_i == `TTCC_OFF_TMR2) ? {16'h0, tmr2_reg} :
    (avs_address_i[1:0] == 2'h0 && ccv_hit[0]) ? {16'h0, ccv_q[0]} :
    (avs_address_i[1:0] == 2'h0 && ccv_hit[1]) ? {16'h0, ccv_q[1]} :
    (avs_address_i[1:0] == 2'h0 && ccv_hit[2]) ? {16'h0, ccv_q[2]} :
    (avs_address_i[1:0] == 2'h0 && ccv_hit[3]) ? {16'h0, ccv_q[3]} : 32'h0;

  // one wait cycle per request, so readdata always comes from a flop
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else if (ce_i) begin
      wait_reg <= ~((avs_read_i | avs_write_i) & wait_reg);
      if (avs_read_i & wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end
  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o = rdata_reg;

  // control registers, merged per byte lane before the narrow store
  wire [15:0] ctrl_m = be_merge({5'h0, ctrl_reg}, wd, be);
  wire [15:0] t2c_m = be_merge({10'h0, t2c_reg}, wd, be);
  wire [15:0] chc_m = be_merge({4'h0, chc_reg}, wd, be);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= `TTCC_RST_CTRL;
      t2c_reg <= `TTCC_RST_TMR2CTL;
      chc_reg <= `TTCC_RST_CHCFG;
    end else if (ce_i) begin
      if (wr_ctrl) ctrl_reg <= ctrl_m[10:0];
      if (wr_t2c) t2c_reg <= t2c_m[5:0];
      if (wr_chc) chc_reg <= chc_m[11:0];
    end
  end

  // sticky flags: write one clears, a new event in the same cycle wins
  wire [8:0] flag_ev = {ch_ev, 1'b0, 1'b0, ovfhi[0], ovf01};
  wire [15:0] clr_m = be_merge(16'h0, wd, be);
  wire [8:0] flag_clr = wr_flg ? clr_m[8:0] : 9'h000;
  logic ext_ev;
  logic ovf2;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_reg <= `TTCC_RST_FLAGS;
    end else if (ce_i) begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_ev // R20
                  | ({8'h0, ovf2} << `TTCC_FLG_TF2) | ({8'h0, ext_ev} << `TTCC_FLG_EXT);
    end
  end

  // ************************************
  // machine tick
  // ************************************
  wire tick_w = div_reg == `TTCC_TICK_DIV - 4'h1;
  // clk_i is the oscillator; one tick every twelve clocks
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_reg <= 4'h0;
    end else if (ce_i) begin
      div_reg <= tick_w ? 4'h0 : div_reg + 4'h1; // R01
    end
  end

  // ************************************
  // timers zero and one
  // ************************************
  wire [1:0] cnt_pin = {timer_one_count_input_i, timer_zero_count_input_i}; // R18
  wire [1:0] gate_pin = {ext_irq_one_gate_i, ext_irq_zero_gate_i}; // R18

  for (genvar i = 0; i < 2; i++) begin : g_t01
    logic [15:0] cnt_reg;
    logic prev_reg;
    wire [4:0] cf = ctrl_reg[`TTCC_T01_STRIDE*i +: `TTCC_T01_STRIDE];
    wire [1:0] md = cf[`TTCC_FLD_MODE +: 2];
    // every falling edge is seen; one clock of pin history is enough
    wire fall = prev_reg & ~cnt_pin[i]; // R02
    wire src = cf[`TTCC_FLD_CNTSEL] ? fall : tick_w;
    wire gate_ok = ~cf[`TTCC_FLD_GATE] | gate_pin[i]; // R07
    wire held = (i == 1) && md == 2'h3; // R06
    wire inc = cf[`TTCC_FLD_RUN] & gate_ok & src & ~held;
    wire [16:0] st = t01_step(cnt_reg, md);
    // split mode: high byte of timer zero ticks on its own run bit
    wire hinc = (i == 0) && md == 2'h3 && ctrl_reg[`TTCC_FLD_RUNHI] && tick_w;
    wire [8:0] hs = {1'b0, cnt_reg[15:8]} + 9'h001;
    assign ovf01[i] = inc & st[16];
    assign ovfhi[i] = hinc & hs[8];
    assign tmr_q[i] = cnt_reg;
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        cnt_reg <= `TTCC_RST_CNT;
        prev_reg <= 1'b0;
      end else if (ce_i) begin
        prev_reg <= cnt_pin[i];
        if (wr_tmr[i]) begin
          cnt_reg <= be_merge(cnt_reg, wd, be);
        end else begin
          cnt_reg <= {hinc ? hs[7:0] : (inc ? st[15:8] : cnt_reg[15:8]), // R01
                      inc ? st[7:0] : cnt_reg[7:0]};
        end
      end
    end
  end

  // ************************************
  // timer two
  // ************************************
  logic t2prev_reg;
  logic trprev_reg;
  logic pre_reg;
  ttcc_pkg::ttcc_src_t src2;
  assign src2 = ttcc_pkg::ttcc_src_t'(t2c_reg[`TTCC_FLD_SRC +: 2]);
  wire t2pin = timer_two_count_gate_input_i; // R17
  wire t2fall = t2prev_reg & ~t2pin;
  wire raw2 = (src2 == ttcc_pkg::TTCC_SRC_TICK && tick_w)
              || (src2 == ttcc_pkg::TTCC_SRC_GATED && tick_w && t2pin) // R08
              || (src2 == ttcc_pkg::TTCC_SRC_PIN && t2fall);
  wire inc2 = raw2 & (~t2c_reg[`TTCC_FLD_PRESC] | pre_reg); // R08
  assign ovf2 = inc2 && tmr2_reg == 16'hFFFF;
  wire trig_fall = trprev_reg & ~timer_two_reload_trigger_i; // R17
  assign ext_ev = trig_fall & t2c_reg[`TTCC_FLD_RLEXT]; // R11
  wire load2 = t2c_reg[`TTCC_FLD_RLEN]
               & (t2c_reg[`TTCC_FLD_RLEXT] ? ext_ev : ovf2); // R10 R11

  // a bus write to the count wins over reload and counting
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tmr2_reg <= `TTCC_RST_CNT;
      t2prev_reg <= 1'b0;
      trprev_reg <= 1'b0;
      pre_reg <= 1'b0;
    end else if (ce_i) begin
      t2prev_reg <= t2pin;
      trprev_reg <= timer_two_reload_trigger_i;
      if (raw2) pre_reg <= ~pre_reg;
      if (wr_tmr2) tmr2_reg <= be_merge(tmr2_reg, wd, be);
      else if (load2) tmr2_reg <= ccv_q[0]; // R10
      else if (inc2) tmr2_reg <= tmr2_reg + 16'h0001;
    end
  end

  // ************************************
  // capture/compare channels
  // ************************************
  for (genvar j = 0; j < 4; j++) begin : g_ch
    logic [15:0] ccv_reg;
    logic pin_prev_reg;
    logic match_prev_reg;
    logic out_reg;
    logic oe_reg;
    ttcc_pkg::ttcc_chan_t cm;
    assign cm = ttcc_pkg::ttcc_chan_t'(chc_reg[2*j +: 2]);
    wire match = cm == ttcc_pkg::TTCC_CH_CMP && tmr2_reg == ccv_reg;
    // only the first cycle of a match counts, so a stopped timer fires once
    wire cmp_ev = match & ~match_prev_reg; // R14
    wire cap_ev = (cm == ttcc_pkg::TTCC_CH_CAP_PIN && (pin_prev_reg ^ capcmp_pin_i[j])) // R12 R19
                  || (cm == ttcc_pkg::TTCC_CH_CAP_WR && wr_ccv[j] && be[0]); // R13
    wire lvl = t2c_reg[`TTCC_FLD_CMPM1] ? chc_reg[`TTCC_FLD_LEVEL + j] : 1'b1;
    assign ch_ev[j] = cmp_ev | cap_ev;
    assign ccv_q[j] = ccv_reg; // R09
    assign capcmp_pin_o[j] = out_reg; // R19
    assign capcmp_pin_oe_o[j] = oe_reg;
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        ccv_reg <= `TTCC_RST_CNT;
        pin_prev_reg <= 1'b0;
        match_prev_reg <= 1'b0;
        out_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else if (ce_i) begin
        pin_prev_reg <= capcmp_pin_i[j];
        match_prev_reg <= match;
        oe_reg <= cm == ttcc_pkg::TTCC_CH_CMP;
        if (cap_ev) ccv_reg <= tmr2_reg; // R12 R13
        else if (wr_ccv[j]) ccv_reg <= be_merge(ccv_reg, wd, be);
        if (cmp_ev) out_reg <= lvl; // R15 R16
        else if (ovf2 && !t2c_reg[`TTCC_FLD_CMPM1]) out_reg <= 1'b0; // R15
      end
    end
  end

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_trig_fall;
    ce_i && timer_two_reload_trigger_i ##1 ce_i && !timer_two_reload_trigger_i;
  endsequence

  a_tick_div_twelve: assert property ( // R01
    ce_i && tick_w ##1 ce_i [*8] |-> !tick_w)
    else $error("tick came sooner than twelve clocks");
  a_mode0_prescale: assert property ( // R03
    ce_i && g_t01[0].inc && !wr_tmr[0] && g_t01[0].md == 2'h0 && tmr_q[0][4:0] != 5'h1F
    |=> tmr_q[0][15:8] == $past(tmr_q[0][15:8])
        && tmr_q[0][4:0] == $past(tmr_q[0][4:0]) + 5'h01)
    else $error("mode 0 high byte moved before prescaler wrap");
  a_mode1_wrap: assert property ( // R04
    ce_i && g_t01[0].inc && !wr_tmr[0] && g_t01[0].md == 2'h1 && tmr_q[0] == 16'hFFFF
    |=> tmr_q[0] == 16'h0000 && flag_reg[`TTCC_FLG_TF0])
    else $error("mode 1 wrap or overflow flag wrong");
  a_mode2_reload: assert property ( // R05
    ce_i && g_t01[0].inc && !wr_tmr[0] && g_t01[0].md == 2'h2 && tmr_q[0][7:0] == 8'hFF
    |=> tmr_q[0][7:0] == $past(tmr_q[0][15:8]) && flag_reg[`TTCC_FLG_TF0])
    else $error("mode 2 reload missed");
  a_mode3_hold: assert property ( // R06
    ce_i && g_t01[1].md == 2'h3 && !wr_tmr[1] |=> $stable(tmr_q[1]))
    else $error("timer one moved in mode 3");
  a_gate_block: assert property ( // R07
    ce_i && ctrl_reg[`TTCC_FLD_GATE + `TTCC_T01_STRIDE] && !ext_irq_one_gate_i
    && !wr_tmr[1] |=> $stable(tmr_q[1]))
    else $error("timer one counted with gate closed");
  a_presc_skip: assert property ( // R08
    ce_i && raw2 && t2c_reg[`TTCC_FLD_PRESC] && !pre_reg && !wr_tmr2 && !load2
    |=> $stable(tmr2_reg) && pre_reg)
    else $error("timer two prescaler did not halve");
  a_reload_ovf: assert property ( // R10
    ce_i && ovf2 && t2c_reg[`TTCC_FLD_RLEN] && !t2c_reg[`TTCC_FLD_RLEXT] && !wr_tmr2
    |=> tmr2_reg == $past(ccv_q[0]) && flag_reg[`TTCC_FLG_TF2])
    else $error("overflow reload missed");
  a_ext_reload: assert property ( // R11
    s_trig_fall ##0 (t2c_reg[`TTCC_FLD_RLEN] && t2c_reg[`TTCC_FLD_RLEXT] && !wr_tmr2)
    |=> tmr2_reg == $past(ccv_q[0]) && flag_reg[`TTCC_FLG_EXT])
    else $error("trigger reload missed");
  a_capture_pin: assert property ( // R12
    ce_i && g_ch[1].cm == ttcc_pkg::TTCC_CH_CAP_PIN
    && capcmp_pin_i[1] != g_ch[1].pin_prev_reg |=> ccv_q[1] == $past(tmr2_reg))
    else $error("pin capture missed");
  a_capture_write: assert property ( // R13
    ce_i && wr_ccv[2] && be[0] && g_ch[2].cm == ttcc_pkg::TTCC_CH_CAP_WR
    |=> ccv_q[2] == $past(tmr2_reg))
    else $error("write capture stored the write data");
  a_compare_set: assert property ( // R15
    ce_i && g_ch[3].cmp_ev && !t2c_reg[`TTCC_FLD_CMPM1]
    |=> capcmp_pin_o[3] && flag_reg[`TTCC_FLG_CH + 3] ##1 !ce_i || capcmp_pin_oe_o[3])
    else $error("compare match did not raise output and flag");
  a_compare_keep: assert property ( // R16
    ce_i && t2c_reg[`TTCC_FLD_CMPM1] && ovf2 && !g_ch[3].cmp_ev |=> $stable(capcmp_pin_o[3]))
    else $error("compare mode 1 output moved on overflow");

endmodule

/* ttcc_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  triple timer with capture/compare unit.
  Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
*/
// Function
// R01 - three 16-bit timers, tick is oscillator/12
// R02 - counter input counts external edges, max osc/24
// R03 - mode 0: 8-bit counter behind /32 prescaler
// R04 - mode 1: full 16-bit counter
// R05 - mode 2: 8-bit counter, auto-reload from high byte
// R06 - mode 3: timer zero split, timer one holds
// R07 - gate input enables counting when programmed
// R08 - timer two: 16-bit, /2 prescaler, gate option
// R09 - four 16-bit capture/compare regs, one reloads
// R10 - reload mode 0: overflow loads reload value
// R11 - reload mode 1: trigger falling edge loads, flags
// R12 - capture mode 0: pin transition latches timer two
// R13 - capture mode 1: low-byte write latches timer two
// R14 - compare match drives output and raises flag
// R15 - compare mode 0: high on match, low on overflow
// R16 - compare mode 1: software level, overflow no change
// R17 - timer two count/gate pin and trigger pin
// R18 - timers zero/one count and gate pins
// R19 - channels zero to three use four pins
// R20 - overflow sets sticky flag, software clears it
`ifndef TTCC_REGS_SVH
`define TTCC_REGS_SVH

// ************************************
// byte offsets
// ************************************
`define TTCC_OFF_CTRL 6'h00
`define TTCC_OFF_TMR2CTL 6'h04
`define TTCC_OFF_CHCFG 6'h08
`define TTCC_OFF_FLAGS 6'h0C
`define TTCC_OFF_TMR0 6'h10
`define TTCC_OFF_TMR1 6'h14
`define TTCC_OFF_TMR2 6'h18
`define TTCC_OFF_CCV0 6'h1C

// ************************************
// field positions
// ************************************
`define TTCC_T01_STRIDE 5
`define TTCC_FLD_MODE 0
`define TTCC_FLD_CNTSEL 2
`define TTCC_FLD_GATE 3
`define TTCC_FLD_RUN 4
`define TTCC_FLD_RUNHI 10
`define TTCC_FLD_SRC 0
`define TTCC_FLD_PRESC 2
`define TTCC_FLD_RLEN 3
`define TTCC_FLD_RLEXT 4
`define TTCC_FLD_CMPM1 5
`define TTCC_FLD_LEVEL 8
`define TTCC_FLG_TF0 0
`define TTCC_FLG_TF1 1
`define TTCC_FLG_TF0H 2
`define TTCC_FLG_TF2 3
`define TTCC_FLG_EXT 4
`define TTCC_FLG_CH 5

// ************************************
// reset values and timing
// ************************************
`define TTCC_RST_CTRL 11'h000
`define TTCC_RST_TMR2CTL 6'h00
`define TTCC_RST_CHCFG 12'h000
`define TTCC_RST_FLAGS 9'h000
`define TTCC_RST_CNT 16'h0000
`define TTCC_TICK_DIV 4'hC

`endif

/* ttcc_pkg.sv */
/*
  Types shared by the timer/capture/compare block.
  Assumes the constants header for all numbers.
*/
package ttcc_pkg;
  // operating mode of timers zero and one
  typedef enum logic [1:0] {
    TTCC_M_PRESC, TTCC_M_FULL, TTCC_M_RELOAD, TTCC_M_SPLIT
  } ttcc_mode_t;
  // count source of timer two
  typedef enum logic [1:0] {
    TTCC_SRC_STOP, TTCC_SRC_TICK, TTCC_SRC_GATED, TTCC_SRC_PIN
  } ttcc_src_t;
  // function of one capture/compare channel
  typedef enum logic [1:0] {
    TTCC_CH_OFF, TTCC_CH_CAP_PIN, TTCC_CH_CMP, TTCC_CH_CAP_WR
  } ttcc_chan_t;
endpackage

/* ttcc_pins_model.sv */
/*
  Far-side model of the timer pins: count inputs, gates, reload trigger and
  capture inputs. Assumes the caller invokes its tasks just after a rising clk_i.
*/
`timescale 1ns/1ps
module ttcc_pins_model (
  // clock
  input wire logic clk_i,
  // pin levels, idle high like pulled-up port pins
  output logic t0_o,
  output logic t1_o,
  output logic g0_o,
  output logic g1_o,
  output logic t2_o,
  output logic trig_o,
  output logic [3:0] cap_o
);
  // ************************************
  // pin drivers
  // ************************************
  // pulled-up lines rest high, so reset release never shows a falling edge
  initial begin
    {t0_o, t1_o, g0_o, g1_o, t2_o, trig_o} = 6'h3F;
    cap_o = 4'hF;
  end

  // 0..3: t0, t1, t2, trigger; 4..7: capture pins; 8, 9: gates
  task automatic set(input int sel, input logic v);
    case (sel)
      0: t0_o <= v;
      1: t1_o <= v;
      2: t2_o <= v;
      3: trig_o <= v;
      8: g0_o <= v;
      9: g1_o <= v;
      default: cap_o[sel-4] <= v;
    endcase
  endtask

  // falling edges 24 clocks apart, the fastest a counter may register
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      set(sel, 1'b0);
      repeat (12) @(posedge clk_i);
      set(sel, 1'b1);
      repeat (12) @(posedge clk_i);
    end
  endtask
endmodule

/* ttcc_top_test.sv */
/*
  Self-checking bench for the triple timer with capture/compare: Avalon-MM
  register tasks plus the pin model. Assumes the register map of ttcc_regs.svh.
*/
`timescale 1ns/1ps
`include "ttcc_regs.svh"
module ttcc_top_test;
  logic clk_i;
  logic sys_rst_i;
  logic ce_i;
  logic [5:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic timer_zero_count_input_i;
  logic timer_one_count_input_i;
  logic ext_irq_zero_gate_i;
  logic ext_irq_one_gate_i;
  logic timer_two_count_gate_input_i;
  logic timer_two_reload_trigger_i;
  logic [3:0] capcmp_pin_i;
  logic [3:0] capcmp_pin_o;
  logic [3:0] capcmp_pin_oe_o;
  logic [3:0] pins_cap;
  logic [31:0] q;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;

  // ************************************
  // design, pin model, clock
  // ************************************
  ttcc_top dut (.clk_i, .sys_rst_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .timer_zero_count_input_i, .timer_one_count_input_i, .ext_irq_zero_gate_i,
    .ext_irq_one_gate_i, .timer_two_count_gate_input_i, .timer_two_reload_trigger_i,
    .capcmp_pin_i, .capcmp_pin_o, .capcmp_pin_oe_o);
  ttcc_pins_model pins (.clk_i(clk_i), .t0_o(timer_zero_count_input_i),
    .t1_o(timer_one_count_input_i), .g0_o(ext_irq_zero_gate_i), .g1_o(ext_irq_one_gate_i),
    .t2_o(timer_two_count_gate_input_i), .trig_o(timer_two_reload_trigger_i),
    .cap_o(pins_cap));
  // a compare channel owns its pin; otherwise the model's level reaches it
  assign capcmp_pin_i = (capcmp_pin_oe_o & capcmp_pin_o) | (~capcmp_pin_oe_o & pins_cap);

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ************************************
  // tasks
  // ************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one Avalon cycle; the idle edge at the end keeps back-to-back calls apart
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rq);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    if (wr) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    // waits as long as the slave needs; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rq = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hF, x);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] rq);
    bus(1'b0, a, 32'h0, 4'hF, rq);
  endtask

  // keeps a control value for exactly 12*k edges: k ticks whatever their phase
  task automatic timed(input logic [5:0] a, input logic [31:0] on, input logic [31:0] off,
                       input int k);
    wr(a, on);
    repeat (12 * k - 3) @(posedge clk_i);
    wr(a, off);
  endtask

  task automatic wait_pin(input logic v);
    n = 0;
    while (capcmp_pin_o[3] !== v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ************************************
  // watchdog and test sequence
  // ************************************
  // the sequence needs under two thousand clocks; 40000 leaves a wide margin
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    avs_address_i = 6'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    // every register clears, the unmapped word too
    for (int i = 0; i < 12; i++) begin
      rd(6'(4 * i), q);
      check("reset value", q, 32'h0);
    end
    wr(6'h2C, 32'hFFFF);
    rd(6'h2C, q);
    check("unmapped", q, 32'h0);
    // timer zero full width through overflow
    wr(`TTCC_OFF_TMR0, 32'hFFFE);
    timed(`TTCC_OFF_CTRL, 32'h11, 32'h0, 3);
    rd(`TTCC_OFF_TMR0, q);
    check("tmr0 mode1", q, 32'h0001);
    rd(`TTCC_OFF_FLAGS, q);
    check("tmr0 flag", q[0], 1'b1);
    wr(`TTCC_OFF_FLAGS, 32'h1);
    rd(`TTCC_OFF_FLAGS, q);
    check("tmr0 flag clear", q[0], 1'b0);
    wr(`TTCC_OFF_TMR0, 32'h80FE);
    timed(`TTCC_OFF_CTRL, 32'h12, 32'h0, 3);
    rd(`TTCC_OFF_TMR0, q);
    check("tmr0 mode2", q, 32'h8081);
    // mode 0: five prescaler bits wrap into the high byte
    wr(`TTCC_OFF_TMR0, 32'h011E);
    timed(`TTCC_OFF_CTRL, 32'h10, 32'h0, 3);
    rd(`TTCC_OFF_TMR0, q);
    check("tmr0 mode0", q, 32'h0201);
    // mode 3: both bytes of timer zero tick, the high byte has its own flag
    wr(`TTCC_OFF_TMR0, 32'hFF00);
    timed(`TTCC_OFF_CTRL, 32'h413, 32'h0, 2);
    rd(`TTCC_OFF_TMR0, q);
    check("tmr0 split", q, 32'h0102);
    rd(`TTCC_OFF_FLAGS, q);
    check("split high flag", q[2], 1'b1);
    // clock enable low freezes a running timer; at most one tick slips through
    wr(`TTCC_OFF_TMR0, 32'h0);
    wr(`TTCC_OFF_CTRL, 32'h11);
    ce_i <= 1'b0;
    repeat (120) @(posedge clk_i);
    ce_i <= 1'b1;
    wr(`TTCC_OFF_CTRL, 32'h0);
    rd(`TTCC_OFF_TMR0, q);
    check("ce freeze", 32'(q < 32'h2), 32'h1);
    // timer one counts pin edges only while its gate is high, holds in mode 3
    wr(`TTCC_OFF_CTRL, 32'h3A0);
    pins.pulse(1, 3);
    pins.set(9, 1'b0);
    pins.pulse(1, 2);
    pins.set(9, 1'b1);
    wr(`TTCC_OFF_CTRL, 32'h3E0);
    pins.pulse(1, 2);
    rd(`TTCC_OFF_TMR1, q);
    check("tmr1 gated count", q, 32'h0003);
    // capture on pin transition and on low-byte write
    wr(`TTCC_OFF_TMR2, 32'h1234);
    wr(`TTCC_OFF_CHCFG, 32'h34);
    pins.set(5, 1'b0);
    repeat (3) @(posedge clk_i);
    pins.set(5, 1'b1);
    rd(6'h20, q);
    check("pin capture", q, 32'h1234);
    rd(`TTCC_OFF_FLAGS, q);
    check("capture flag", q[6], 1'b1);
    bus(1'b1, 6'h24, 32'h00AA, 4'h1, q);
    rd(6'h24, q);
    check("write capture", q, 32'h1234);
    // reload by trigger edge, then by overflow
    wr(`TTCC_OFF_CCV0, 32'hABCD);
    wr(`TTCC_OFF_TMR2, 32'h0);
    wr(`TTCC_OFF_TMR2CTL, 32'h18);
    pins.pulse(3, 1);
    rd(`TTCC_OFF_TMR2, q);
    check("trigger reload", q, 32'hABCD);
    rd(`TTCC_OFF_FLAGS, q);
    check("trigger flag", q[4], 1'b1);
    wr(`TTCC_OFF_TMR2, 32'hFFFE);
    timed(`TTCC_OFF_TMR2CTL, 32'h09, 32'h08, 3);
    rd(`TTCC_OFF_TMR2, q);
    check("overflow reload", q, 32'hABCE);
    // prescaler halves four ticks; gate low stops, high lets three through
    wr(`TTCC_OFF_TMR2, 32'h0100);
    timed(`TTCC_OFF_TMR2CTL, 32'h05, 32'h0, 4);
    pins.set(2, 1'b0);
    timed(`TTCC_OFF_TMR2CTL, 32'h02, 32'h0, 3);
    pins.set(2, 1'b1);
    timed(`TTCC_OFF_TMR2CTL, 32'h02, 32'h0, 3);
    wr(`TTCC_OFF_TMR2CTL, 32'h03);
    pins.pulse(2, 3);
    wr(`TTCC_OFF_TMR2CTL, 32'h0);
    rd(`TTCC_OFF_TMR2, q);
    check("tmr2 prescale gate pin", q, 32'h0108);
    // compare mode 0 on channel three: high at match, low at overflow
    wr(`TTCC_OFF_FLAGS, 32'h1FF);
    wr(`TTCC_OFF_CHCFG, 32'h80);
    // the enable flop follows the config one edge after the write lands
    @(posedge clk_i);
    check("compare drive", capcmp_pin_oe_o, 4'h8);
    wr(6'h28, 32'hFFF8);
    wr(`TTCC_OFF_TMR2, 32'hFFF0);
    wr(`TTCC_OFF_TMR2CTL, 32'h01);
    wait_pin(1'b1);
    wait_pin(1'b0);
    check("cmp0 width", 32'(n >= 94 && n <= 98), 32'h1);
    rd(`TTCC_OFF_FLAGS, q);
    check("match and ovf flags", {q[8], q[3]}, 2'h3);
    // compare mode 1: software level survives overflow
    wr(`TTCC_OFF_TMR2CTL, 32'h21);
    wr(`TTCC_OFF_CHCFG, 32'h880);
    wr(`TTCC_OFF_TMR2, 32'hFFF0);
    wait_pin(1'b1);
    repeat (150) @(posedge clk_i);
    check("cmp1 hold", capcmp_pin_o[3], 1'b1);
    wr(`TTCC_OFF_CHCFG, 32'h080);
    wr(`TTCC_OFF_TMR2, 32'hFFF0);
    wait_pin(1'b0);
    check("cmp1 low level", 32'(n < 300), 32'h1);
    wrap_up();
  end
endmodule
